// ---- include/rgd_chan_if.sv ----
// carrier between the decoder sequence and one channel decoder
// assumes the channel decoder is purely combinational
`timescale 1ns/1ps
`default_nettype none
interface rgd_chan_if;
  logic [63:0] blk;         // one 64-bit channel half, byte 0 in bits 7:0
  logic [1:0] rx;           // texel column inside block
  logic [1:0] ry;           // texel row inside block
  logic sgn;                // endpoints are two's complement
  logic signed [15:0] val;  // decoded channel, 1.0 = 2^14

  modport src (output blk, output rx, output ry, output sgn, input val);
  modport dec (input blk, input rx, input ry, input sgn, output val);
endinterface
`default_nettype wire

// ---- include/rgd_pkg.sv ----
// shared constants and types of the red/green block texture decoder
// assumes one clock domain; fixed-point results use 1.0 = 2^14
package rgd_pkg;

  // texture formats, as presented with each request
  typedef enum logic [1:0] {
    unsigned_one_channel_format = 2'h0,
    signed_one_channel_format = 2'h1,
    unsigned_two_channel_format = 2'h2,
    signed_two_channel_format = 2'h3
  } rgd_fmt_e;

  // decoder sequence
  typedef enum logic [2:0] {
    RGD_IDLE,
    RGD_FETCH,
    RGD_WAIT,
    RGD_DECODE,
    RGD_OUT
  } rgd_state_e;

  // block geometry
  localparam int unsigned RGD_BLK_DIM = 4;               // texels per block side
  localparam int unsigned RGD_BLK_SHIFT = 2;             // log2 of block side
  localparam int unsigned RGD_BS1_SHIFT = 3;             // 8-byte block, one channel
  localparam int unsigned RGD_BS2_SHIFT = 4;             // 16-byte block, two channels
  localparam int unsigned RGD_HALF_BITS = 64;            // bits per channel half
  localparam int unsigned RGD_IDX_LSB = 16;              // index vector starts after two endpoint bytes
  localparam int unsigned RGD_CODE_W = 3;                // selector width

  // interpolation
  localparam logic [3:0] RGD_DIV7 = 4'h7;                // eight-value mode divisor
  localparam logic [3:0] RGD_DIV5 = 4'h5;                // six-value mode divisor
  localparam logic [8:0] RGD_U_SCALE = 9'hff;            // unsigned endpoint full scale
  localparam logic [8:0] RGD_S_SCALE = 9'h7f;            // signed endpoint full scale
  localparam logic signed [9:0] RGD_S_MOST_NEG = -10'sd128;
  localparam logic signed [9:0] RGD_S_CLAMP = -10'sd127; // -128 unpacks like -127
  localparam int unsigned RGD_FRAC = 14;                 // fraction bits of a result
  localparam logic signed [15:0] RGD_ONE = 16'sh4000;    // +1.0
  localparam logic signed [15:0] RGD_NEG_ONE = -16'sh4000; // -1.0
  localparam logic signed [15:0] RGD_ZERO = 16'sh0000;   // 0.0

  // reset values
  localparam logic [31:0] RGD_RST_WORD = 32'h0000_0000;
  localparam logic [127:0] RGD_RST_BLK = 128'h0;
  localparam logic [1:0] RGD_RST_SYNC = 2'h0;

  // whole state of the top module apart from its reset synchroniser
  typedef struct packed {
    rgd_state_e st;
    rgd_fmt_e fmt;
    logic [1:0] rx;
    logic [1:0] ry;
    logic [31:0] addr;
    logic [31:0] img_bytes;
    logic [127:0] blk;
    logic signed [15:0] r;
    logic signed [15:0] g;
  } rgd_top_s;

endpackage

// ---- logic/rgd_channel.sv ----
// one channel decoder: endpoints, selector and interpolation of a 64-bit half
// assumes inputs are held stable by the caller; result is combinational
`timescale 1ns/1ps
`default_nettype none
module rgd_channel (
  rgd_chan_if.dec ch
);
  import rgd_pkg::*;

  logic [7:0] e0_raw;           // first endpoint byte
  logic [7:0] e1_raw;           // second endpoint byte
  logic [47:0] idx_bits;        // little-endian index vector
  logic [2:0] code;             // selector of this texel
  logic [5:0] pos;              // lsb of selector in index vector
  logic eight_mode;             // first endpoint exceeds second
  logic signed [9:0] e0;        // unpacked endpoint numerators
  logic signed [9:0] e1;
  logic [3:0] w0;               // endpoint weights
  logic [3:0] w1;
  logic signed [15:0] num;      // weighted sum
  logic [24:0] mag;             // |num| scaled to fraction bits
  logic [24:0] quo;             // rounded quotient
  logic neg;                    // sum is negative

  // endpoint bytes first, then six index bytes, lowest address least significant
  assign e0_raw = ch.blk[7:0];
  assign e1_raw = ch.blk[15:8];
  assign idx_bits = ch.blk[RGD_IDX_LSB +: 48];
  // selector sits at bits 3*(4y+x)+2..3*(4y+x)
  assign pos = 6'(RGD_CODE_W * {ch.ry, ch.rx});
  assign code = idx_bits[pos +: RGD_CODE_W];

  // mode compare on raw bytes; signed pair -127/-128 takes the eight-value side
  assign eight_mode = ch.sgn ? ($signed(e0_raw) > $signed(e1_raw)) : (e0_raw > e1_raw);

  // unpack numerators: unsigned over 255, signed over 127 with -128 held at -1.0
  always_comb begin
    e0 = ch.sgn ? 10'($signed(e0_raw)) : $signed({2'b00, e0_raw});
    e1 = ch.sgn ? 10'($signed(e1_raw)) : $signed({2'b00, e1_raw});
    if (ch.sgn && (e0 == RGD_S_MOST_NEG)) begin
      e0 = RGD_S_CLAMP;
    end
    if (ch.sgn && (e1 == RGD_S_MOST_NEG)) begin
      e1 = RGD_S_CLAMP;
    end
  end

  // weights per selector; endpoints use the full divisor on one side
  always_comb begin
    w0 = 4'h0;
    w1 = 4'h0;
    if (code == 3'h0) begin
      w0 = eight_mode ? RGD_DIV7 : RGD_DIV5;
    end else if (code == 3'h1) begin
      w1 = eight_mode ? RGD_DIV7 : RGD_DIV5;
    end else if (eight_mode) begin
      w0 = 4'(4'h8 - {1'b0, code});
      w1 = 4'({1'b0, code} - 4'h1);
    end else begin
      w0 = 4'(4'h6 - {1'b0, code});
      w1 = 4'({1'b0, code} - 4'h1);
    end
  end

  // weighted sum and its magnitude in fraction units
  always_comb begin
    // operands widened to 16 bits first so the product cannot wrap at 10 bits
    num = ($signed({12'h000, w0}) * 16'(e0)) + ($signed({12'h000, w1}) * 16'(e1));
    neg = num[15];
    mag = neg ? 25'(-num) << RGD_FRAC : 25'(num) << RGD_FRAC;
  end

  // rounded divide by divisor times scale, four constant cases
  always_comb begin
    unique case ({eight_mode, ch.sgn})
      2'b10: quo = 25'((mag + 25'(7 * 255 / 2)) / 25'(7 * 255));
      2'b11: quo = 25'((mag + 25'(7 * 127 / 2)) / 25'(7 * 127));
      2'b00: quo = 25'((mag + 25'(5 * 255 / 2)) / 25'(5 * 255));
      2'b01: quo = 25'((mag + 25'(5 * 127 / 2)) / 25'(5 * 127));
    endcase
  end

  // six-value mode ends in channel minimum and maximum
  always_comb begin
    if (!eight_mode && (code == 3'h6)) begin
      ch.val = ch.sgn ? RGD_NEG_ONE : RGD_ZERO;
    end else if (!eight_mode && (code == 3'h7)) begin
      ch.val = RGD_ONE;
    end else begin
      ch.val = neg ? -$signed(quo[15:0]) : $signed(quo[15:0]);
    end
  end
endmodule
`default_nettype wire

// ---- logic/rgd_decoder.sv ----
// top of the red/green block texture decoder: request, block fetch, decode, result
// assumes a memory port that returns one whole block per read, byte 0 in bits 7:0,
// and a requester that holds its request fields while req_valid is high
`timescale 1ns/1ps
`default_nettype none
// Function
// - image is raster of 4x4 blocks, 64/128 bits
// - texels outside small images are don't-care
// - block 8 or 16 bytes; image size product
// - block offset from block row and column
// - texel found by x mod 4, y mod 4
// - block: endpoint, endpoint, six index bytes
// - index bytes assembled little-endian, 48 bits
// - selector is three bits at 3*(4y+x)
// - first greater: eight values, divide by seven
// - otherwise six values plus minimum and maximum
// - unsigned one channel gives (R,0,0,1)
// - signed formats compare two's complement endpoints
// - signed unpack over 127, -128 is -1
// - pair -127/-128 may pick either mode
// - two channel: first half red, second green
// - unsigned two channel gives (R,G,0,1)
// - signed two channel uses signed halves
module rgd_decoder (
  input wire logic clk_sys,
  input wire logic rst_n,
  // decode request
  input wire logic req_valid,
  output logic req_ready,
  input wire rgd_pkg::rgd_fmt_e req_fmt,
  input wire logic [31:0] req_base,
  input wire logic [15:0] req_width,
  input wire logic [15:0] req_height,
  input wire logic [15:0] req_x,
  input wire logic [15:0] req_y,
  // block read from memory
  output logic mem_valid,
  input wire logic mem_ready,
  output logic [31:0] mem_addr,
  output logic mem_wide,
  input wire logic mem_rsp_valid,
  input wire logic [127:0] mem_rsp_data,
  // decoded texel
  output logic out_valid,
  input wire logic out_ready,
  output logic signed [15:0] out_r,
  output logic signed [15:0] out_g,
  output logic signed [15:0] out_b,
  output logic signed [15:0] out_a,
  output logic [31:0] out_img_bytes
);
  import rgd_pkg::*;

  logic [1:0] rst_sync_ff;       // reset release synchroniser
  logic rst_int_n;               // synchronised reset
  rgd_top_s st_ff;               // registered state
  rgd_top_s nxt_st;              // next state
  logic [31:0] blk_cols;         // blocks per row, ceil(w/4)
  logic [31:0] blk_rows;         // blocks per column, ceil(h/4)
  logic [31:0] blk_index;        // raster index of the block
  logic [31:0] blk_offset;       // byte offset of the block
  logic [31:0] img_size;         // total image bytes
  logic req_two;                 // request is a two-channel format
  logic st_two;                  // held format is two-channel
  logic st_sgn;                  // held format is signed

  rgd_chan_if red_if ();         // first half, red
  rgd_chan_if green_if ();       // second half, green

  // reset asserts at once and releases after two clock edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= RGD_RST_SYNC;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_ff[1];

  // format decode of request and of held state
  assign req_two = (req_fmt == unsigned_two_channel_format) || (req_fmt == signed_two_channel_format);
  assign st_two = (st_ff.fmt == unsigned_two_channel_format) || (st_ff.fmt == signed_two_channel_format);
  assign st_sgn = (st_ff.fmt == signed_one_channel_format) || (st_ff.fmt == signed_two_channel_format);

  // block geometry of the request; height is only used for the image size,
  // so texels past a small image's edge simply decode whatever the block holds
  always_comb begin
    blk_cols = (32'(req_width) + 32'(RGD_BLK_DIM - 1)) >> RGD_BLK_SHIFT;
    blk_rows = (32'(req_height) + 32'(RGD_BLK_DIM - 1)) >> RGD_BLK_SHIFT;
    blk_index = 32'(blk_cols * 32'(req_y >> RGD_BLK_SHIFT)) + 32'(req_x >> RGD_BLK_SHIFT);
    if (req_two) begin
      blk_offset = blk_index << RGD_BS2_SHIFT;
      img_size = 32'(blk_cols * blk_rows) << RGD_BS2_SHIFT;
    end else begin
      blk_offset = blk_index << RGD_BS1_SHIFT;
      img_size = 32'(blk_cols * blk_rows) << RGD_BS1_SHIFT;
    end
  end

  // channel decoders see the held block and in-block position
  assign red_if.blk = st_ff.blk[RGD_HALF_BITS - 1:0];
  assign green_if.blk = st_ff.blk[2 * RGD_HALF_BITS - 1:RGD_HALF_BITS];
  assign red_if.rx = st_ff.rx;
  assign red_if.ry = st_ff.ry;
  assign green_if.rx = st_ff.rx;
  assign green_if.ry = st_ff.ry;
  assign red_if.sgn = st_sgn;
  assign green_if.sgn = st_sgn;

  // red channel decoder
  rgd_channel u_red (
    .ch (red_if)
  );

  // green channel decoder, same logic as red
  rgd_channel u_green (
    .ch (green_if)
  );

  // sequence: take request, read block, decode, hold result
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.st)
      RGD_IDLE: begin
        // latch format, position and address
        if (req_valid) begin
          nxt_st.fmt = req_fmt;
          nxt_st.rx = req_x[1:0];
          nxt_st.ry = req_y[1:0];
          nxt_st.addr = req_base + blk_offset;
          nxt_st.img_bytes = img_size;
          nxt_st.st = RGD_FETCH;
        end
      end
      RGD_FETCH: begin
        // read request held until memory takes it
        if (mem_ready) begin
          nxt_st.st = RGD_WAIT;
        end
      end
      RGD_WAIT: begin
        // one-channel blocks use only the low 64 bits
        if (mem_rsp_valid) begin
          if (st_two) begin
            nxt_st.blk = mem_rsp_data;
          end else begin
            nxt_st.blk = {64'h0, mem_rsp_data[RGD_HALF_BITS - 1:0]};
          end
          nxt_st.st = RGD_DECODE;
        end
      end
      RGD_DECODE: begin
        // capture the channels; green is zero for one-channel formats
        nxt_st.r = red_if.val;
        nxt_st.g = st_two ? green_if.val : RGD_ZERO;
        nxt_st.st = RGD_OUT;
      end
      RGD_OUT: begin
        // result held until taken
        if (out_ready) begin
          nxt_st.st = RGD_IDLE;
        end
      end
    endcase
  end

  // state register on the synchronised reset
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      st_ff.st <= RGD_IDLE;
      st_ff.fmt <= unsigned_one_channel_format;
      st_ff.rx <= 2'h0;
      st_ff.ry <= 2'h0;
      st_ff.addr <= RGD_RST_WORD;
      st_ff.img_bytes <= RGD_RST_WORD;
      st_ff.blk <= RGD_RST_BLK;
      st_ff.r <= RGD_ZERO;
      st_ff.g <= RGD_ZERO;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // handshakes from state; data from registers, blue and alpha constant
  assign req_ready = (st_ff.st == RGD_IDLE);
  assign mem_valid = (st_ff.st == RGD_FETCH);
  assign mem_addr = st_ff.addr;
  assign mem_wide = st_two;
  assign out_valid = (st_ff.st == RGD_OUT);
  assign out_r = st_ff.r;
  assign out_g = st_ff.g;
  assign out_b = RGD_ZERO;
  assign out_a = RGD_ONE;
  assign out_img_bytes = st_ff.img_bytes;
endmodule
`default_nettype wire

// ---- tb/red_green_block_texture_decoder_tb_top.sv ----
// bench of the block texture decoder: a table of requests, then a reset in mid-read
// assumes the memory model answers with blk after lat cycles
`timescale 1ns/1ps
`default_nettype none
module red_green_block_texture_decoder_tb_top;
  import rgd_pkg::*;
  localparam logic [47:0] IX_UP = 48'hfac688fac688; // codes 0..7 rising
  localparam logic [47:0] IX_DN = 48'h053977053977; // codes 7..0 falling
  localparam logic [63:0] JUNK = 64'h5a5aa5a50f0ff0f0; // unused half of a narrow block
  // one request: format, image size, block column and row, base, block, latency,
  // then the block address and the image size in bytes that it must give
  typedef struct {
    logic [1:0] fmt;
    logic [15:0] w, h, bx, by;
    logic [31:0] base;
    logic [127:0] blk;
    logic [3:0] lat;
    logic [31:0] exp_addr, exp_bytes;
  } rgd_row_s;
  rgd_row_s rows [6] = '{
    '{2'h0, 16'd13, 16'd9, 16'd2, 16'd1, 32'h1000, {JUNK, IX_UP, 8'h10, 8'hc8}, 4'h0,
      32'h1030, 32'h60},
    '{2'h0, 16'd3, 16'd2, 16'd0, 16'd0, 32'h2004, {JUNK, IX_DN, 8'hc8, 8'h10}, 4'h2,
      32'h2004, 32'h8},
    '{2'h1, 16'd13, 16'd9, 16'd3, 16'd2, 32'h3000, {JUNK, IX_UP, 8'h80, 8'h81}, 4'h1,
      32'h3058, 32'h60},
    '{2'h1, 16'd13, 16'd9, 16'd0, 16'd1, 32'h3000, {JUNK, IX_DN, 8'h7f, 8'h80}, 4'h0,
      32'h3020, 32'h60},
    '{2'h2, 16'd8, 16'd8, 16'd1, 16'd1, 32'h4000, {IX_DN, 8'hff, 8'h00, IX_UP, 8'h00, 8'hff}, 4'h3,
      32'h4030, 32'h40},
    '{2'h3, 16'h100, 16'h44, 16'd63, 16'd16, 32'hfffff000, {IX_UP, 8'h05, 8'h80, IX_DN, 8'hc0, 8'h40}, 4'h1,
      32'h000033f0, 32'h4400}
  };
  logic clk_sys = 1'b0, rst_n = 1'b0, req_valid = 1'b0, out_ready = 1'b0;
  rgd_fmt_e req_fmt = unsigned_one_channel_format;
  logic [31:0] req_base = '0, mem_addr, out_img_bytes, got_addr;
  logic [15:0] req_width = '0, req_height = '0, req_x = '0, req_y = '0;
  logic [127:0] blk = '0, mem_rsp_data;
  logic [3:0] lat = '0;
  logic req_ready, mem_valid, mem_ready, mem_wide, mem_rsp_valid, out_valid;
  logic signed [15:0] out_r, out_g, out_b, out_a;
  int n_errors = 0, n_checks = 0;
  rgd_decoder uut (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_fmt(req_fmt), .req_base(req_base), .req_width(req_width), .req_height(req_height), .req_x(req_x),
    .req_y(req_y), .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_addr(mem_addr), .mem_wide(mem_wide),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_r(out_r), .out_g(out_g), .out_b(out_b), .out_a(out_a), .out_img_bytes(out_img_bytes));
  rgd_mem_model u_mem (.clk_sys(clk_sys), .mem_valid(mem_valid), .mem_addr(mem_addr), .blk(blk), .lat(lat),
    .mem_ready(mem_ready), .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data), .got_addr(got_addr));
  // one edge, then settle
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // n/d in units of 2^14, half away from zero
  function automatic logic signed [15:0] q14(longint n, longint d);
    longint a;
    a = (n < 0) ? -n : n;
    a = (a * 32768 + d) / (2 * d);
    return 16'((n < 0) ? -a : a);
  endfunction
  // expected channel of texel t of a 64-bit half
  function automatic logic signed [15:0] chan(logic [63:0] h, int t, logic sg);
    longint e0, e1, v0, v1, s, sc;
    s = longint'((h >> (16 + 3 * t)) & 64'h7);
    e0 = sg ? longint'($signed(h[7:0])) : longint'(h[7:0]);
    e1 = sg ? longint'($signed(h[15:8])) : longint'(h[15:8]);
    v0 = (e0 == -128) ? -127 : e0;
    v1 = (e1 == -128) ? -127 : e1;
    sc = sg ? 127 : 255;
    if (s < 2) return q14(s == 0 ? v0 : v1, sc);
    if (e0 > e1) return q14((8 - s) * v0 + (s - 1) * v1, 7 * sc);
    if (s == 6) return sg ? -16'sh4000 : 16'sh0000;
    if (s == 7) return 16'sh4000;
    return q14((6 - s) * v0 + (s - 1) * v1, 5 * sc);
  endfunction
  // one texel request up to the handshake of its result
  task automatic run_one(rgd_row_s rw, int t);
    blk = rw.blk;
    lat = rw.lat;
    req_fmt = rgd_fmt_e'(rw.fmt);
    req_base = rw.base;
    req_width = rw.w;
    req_height = rw.h;
    req_x = 16'(rw.bx * 4 + t % 4);
    req_y = 16'(rw.by * 4 + t / 4);
    req_valid = 1'b1;
    for (int k = 0; k < 20 && req_ready !== 1'b1; k++) step();
    step();
    req_valid = 1'b0;
    for (int k = 0; k < 60 && out_valid !== 1'b1; k++) step();
    repeat (rw.lat) step(); // consumer stalls, result must stand
    chk(32'(out_valid), 32'h1);
    // address and image size are defined even for texels past a small image's edge
    chk(got_addr, rw.exp_addr);
    chk(out_img_bytes, rw.exp_bytes);
    if (req_x < rw.w && req_y < rw.h) begin
      chk(32'(out_r), 32'(chan(rw.blk[63:0], t, rw.fmt[0])));
      chk(32'(out_g), rw.fmt[1] ? 32'(chan(rw.blk[127:64], t, rw.fmt[0])) : 32'h0);
      chk({out_b, out_a}, 32'h00004000);
    end
    out_ready = 1'b1;
    step();
    out_ready = 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // watchdog, well beyond the fewer than one thousand cycles of traffic
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  // reset, table of requests, then a reset while a read is outstanding
  initial begin
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (3) step();
    // idle, ready and cleared once the internal reset has let go
    chk(32'({req_ready, mem_valid, out_valid}), 32'h4);
    chk(32'({out_r, out_g}), 32'h0);
    chk(out_img_bytes, 32'h0);
    $display("reset release test done");
    foreach (rows[i]) begin
      for (int t = 0; t < 16; t++) run_one(rows[i], t);
      $display("row %0d done", i);
    end
    lat = 4'h8;
    req_valid = 1'b1;
    for (int k = 0; k < 20 && req_ready !== 1'b1; k++) step();
    step();
    req_valid = 1'b0;
    repeat (3) step();
    rst_n = 1'b0;
    #1 chk(32'({mem_valid, out_valid}), 32'h0);
    chk(32'({out_r, out_g}), 32'h0); // stale result cleared by reset
    chk(32'(out_a), 32'h4000);
    step();
    rst_n = 1'b1;
    repeat (30) step();
    chk(32'({req_ready, out_valid}), 32'h2); // the late answer is ignored, still idle
    run_one(rows[4], 6);
    $display("reset test done");
    complete_run();
  end
endmodule
`default_nettype wire

// ---- tb/rgd_decoder_assertions.sv ----
// checker of the block texture decoder, on the top module's ports only
// assumes one clock domain; bound to the decoder below the module
`timescale 1ns/1ps
`default_nettype none
module rgd_dec_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire rgd_pkg::rgd_fmt_e req_fmt,
  input wire logic mem_valid,
  input wire logic mem_ready,
  input wire logic [31:0] mem_addr,
  input wire logic mem_wide,
  input wire logic mem_rsp_valid,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic signed [15:0] out_r,
  input wire logic signed [15:0] out_g,
  input wire logic signed [15:0] out_b,
  input wire logic signed [15:0] out_a
);
  import rgd_pkg::*;
  logic [1:0] fmt_ff; // format of the request in flight
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // remember the format of the last accepted request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fmt_ff <= 2'h0;
    end else if (req_valid && req_ready) begin
      fmt_ff <= req_fmt;
    end
  end
  // a taken request is followed at once by its block read
  AST_REQ_MEM: assert property (req_valid && req_ready |=> mem_valid && !req_ready)
    else $error("no block read after an accepted request");
  AST_MEM_HOLD: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr))
    else $error("block read dropped or moved before acceptance");
  AST_WIDE: assert property (mem_valid |-> mem_wide == fmt_ff[1])
    else $error("block size does not follow the format");
  AST_RSP_OUT: assert property (mem_rsp_valid && !mem_valid && !out_valid && !req_ready
    |=> !out_valid ##1 out_valid)
    else $error("result not two cycles after the block");
  AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_r) && $stable(out_g))
    else $error("result changed while stalled");
  AST_BA: assert property (out_valid |-> out_b == 16'sh0000 && out_a == 16'sh4000)
    else $error("blue or alpha wrong");
  AST_ONE_G: assert property (out_valid && !fmt_ff[1] |-> out_g == 16'sh0000)
    else $error("green not zero for one channel");
  AST_BACK: assert property (out_valid && out_ready |=> !out_valid && req_ready)
    else $error("not ready again after the result");
endmodule
bind rgd_decoder rgd_dec_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
  .req_ready(req_ready), .req_fmt(req_fmt), .mem_valid(mem_valid), .mem_ready(mem_ready),
  .mem_addr(mem_addr), .mem_wide(mem_wide), .mem_rsp_valid(mem_rsp_valid), .out_valid(out_valid),
  .out_ready(out_ready), .out_r(out_r), .out_g(out_g), .out_b(out_b), .out_a(out_a));
`default_nettype wire

// ---- tb/rgd_mem_model.sv ----
// memory partner: takes one block read, then answers with the block set by the bench
// assumes blk and lat are set before the request; idle data lines show all ones, then the inverse of the last block
`timescale 1ns/1ps
`default_nettype none
module rgd_mem_model (
  input wire logic clk_sys,
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [127:0] blk,
  input wire logic [3:0] lat,
  output var logic mem_ready,
  output var logic mem_rsp_valid,
  output var logic [127:0] mem_rsp_data,
  output var logic [31:0] got_addr
);
  // one read at a time: lat cycles to accept, lat more to answer
  initial begin
    mem_ready = 1'b0;
    mem_rsp_valid = 1'b0;
    mem_rsp_data = '1;
    got_addr = '0;
    forever begin
      @(posedge clk_sys);
      #1;
      if (mem_valid === 1'b1) begin
        repeat (lat) @(posedge clk_sys);
        #1 mem_ready = 1'b1;
        got_addr = mem_addr; // address of the read, standing since the request
        @(posedge clk_sys);
        #1 mem_ready = 1'b0;
        repeat (lat) @(posedge clk_sys);
        #1 mem_rsp_valid = 1'b1;
        mem_rsp_data = blk; // whole block, byte 0 lowest
        @(posedge clk_sys);
        #1 mem_rsp_valid = 1'b0;
        mem_rsp_data = ~blk; // released lines no longer show the block
      end
    end
  end
endmodule
`default_nettype wire
